// [psi_buf_reg.sv]
/*
 * Buffered register: a write lands in the buffer, the active copy loads
 * either every clock or only on a load pulse.
 * Assumes clock and synchronous reset shared with the parent.
 */
`timescale 1ns/100ps
module psi_buf_reg #(
	parameter int WIDTH = 4
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic wr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic sync_sel_i,
	input wire logic load_i,
	output logic [WIDTH-1:0] buf_o,
	output logic [WIDTH-1:0] act_o
);
	logic [WIDTH-1:0] buf_q;
	logic [WIDTH-1:0] act_q;
	logic take;

	// Selected mode: follow buffer every edge, or wait for synchronization
	assign take = !sync_sel_i || load_i;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			buf_q <= '0;
			act_q <= '0;
		end else begin
			if (wr_i) buf_q <= wdata_i;
			if (take) act_q <= buf_q;
		end
	end

	assign buf_o = buf_q;
	assign act_o = act_q;
endmodule // psi_buf_reg

// [psi_consts.svh]
/*
 * Constants for the PWM synchronization configuration and pair-invert block.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef PSI_CONSTS_SVH
`define PSI_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (word offsets on the plain register port)
// ----------------------------------------------------------------
`define PSI_ADDR_W 4
`define PSI_REG_SYNC_CFG 4'h0
`define PSI_REG_INV_CTRL 4'h1
`define PSI_REG_INV_ACTIVE 4'h2
`define PSI_REG_TRIG_CTRL 4'h3
`define PSI_REG_OUTCTL 4'h4
`define PSI_REG_STATUS 4'h5

// ----------------------------------------------------------------
// Field positions of sync_configuration
// ----------------------------------------------------------------
`define PSI_B_HOLD_MODE 0
`define PSI_B_INIT_SEL 2
`define PSI_B_INV_SEL 4
`define PSI_B_OUTCTL_SEL 5
`define PSI_B_SYNC_MODE 7
`define PSI_B_SW_COUNTER 8
`define PSI_B_SW_WRBUF 9
`define PSI_B_SW_OUTPUT_MASK_REGISTER 10
`define PSI_B_SW_INVERT 11
`define PSI_B_SW_OUTCTL 12
`define PSI_B_HW_COUNTER 16
`define PSI_B_HW_OUTCTL 20
`define PSI_SYNC_CFG_MASK 32'h001F1FB5
`define PSI_INV_MASK 32'h0000000F
`define PSI_TRIG_MASK 32'h00000007
`define PSI_OUTCTL_MASK 32'h0000FFFF
`define PSI_SYNC_CFG_RST 32'h00000000
`define PSI_INV_RST 32'h00000000

`endif

// [psi_pair_swap.sv]
/*
 * Channel-pair output swap.
 * Assumes channel outputs in order, pair m being channels 2m and 2m+1.
 */
`timescale 1ns/100ps
module psi_pair_swap #(
	parameter int PAIRS = 4
) (
	input wire logic [PAIRS-1:0] inv_en_i,
	input wire logic [2*PAIRS-1:0] ch_i,
	output logic [2*PAIRS-1:0] ch_o
);
	genvar m;
	generate
		for (m = 0; m < PAIRS; m++) begin : g_pair
			assign ch_o[2*m] = inv_en_i[m] ? ch_i[2*m+1] : ch_i[2*m];
			assign ch_o[2*m+1] = inv_en_i[m] ? ch_i[2*m] : ch_i[2*m+1];
		end
	endgenerate
endmodule // psi_pair_swap

// [psi_pkg.sv]
/*
 * Types shared by the pair-invert block files.
 * Assumes the constants header is on the include path.
 */
package psi_pkg;
	// ----------------------------------------------------------------
	// Load pulses, one per synchronized target
	// ----------------------------------------------------------------
	typedef struct packed {
		logic outctl;
		logic invert;
		logic output_mask_register;
		logic wrbuf;
		logic counter;
	} psi_sync_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} psi_bus_t;
endpackage

// [psi_sync_checker.sv]
/* Port-level checker for psi_sync_ctrl: read data, loads, trigger pulses.
 * Assumes it is bound to psi_sync_ctrl and shares its clock and reset. */
`timescale 1ns/100ps
`include "psi_consts.svh"
module psi_sync_checker #(
	parameter int PAIRS = 4,
	parameter int HW_TRIGS = 3,
	parameter int INIT_W = 16
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic sw_trig_i,
	input wire logic [HW_TRIGS-1:0] hw_trig_i,
	input wire logic cnt_boundary_i,
	input wire logic [INIT_W-1:0] init_buf_i,
	input wire logic [2*PAIRS-1:0] ch_i,
	input wire logic [2*PAIRS-1:0] ch_o,
	input wire logic [15:0] outctl_o,
	input wire logic [INIT_W-1:0] init_o,
	input wire psi_pkg::psi_sync_t sync_o,
	input wire logic enhanced_o
);
	// ----
	// Shadow buffers, so loads can be judged from the ports alone
	// ----
	logic [31:0] cfg_q;
	logic [15:0] ob_q;
	logic [PAIRS-1:0] ib_q;
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cfg_q <= 32'h0;
			ob_q <= 16'h0;
			ib_q <= '0;
		end else if (reg_wr_i) begin
			if (reg_addr_i == 4'h0) cfg_q <= reg_wdata_i & `PSI_SYNC_CFG_MASK;
			if (reg_addr_i == 4'h4) ob_q <= reg_wdata_i[15:0];
			if (reg_addr_i == 4'h1) ib_q <= reg_wdata_i[PAIRS-1:0];
		end
	end
	function automatic logic [2*PAIRS-1:0] swp(input logic [PAIRS-1:0] en,
		input logic [2*PAIRS-1:0] c);
		logic [2*PAIRS-1:0] r;
		r = c;
		for (int m = 0; m < PAIRS; m++) if (en[m]) r[2*m+:2] = {c[2*m], c[2*m+1]};
		return r;
	endfunction
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside read slot");
	cfg_resv_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 4'h0 |->
		(reg_rdata_o & ~`PSI_SYNC_CFG_MASK) == 32'h0) else $error("config reserved bit set");
	inv_resv_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) inside {4'h1, 4'h2} |->
		reg_rdata_o[31:4] == 28'h0) else $error("invert reserved bit set");
	unmapped_zero_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) > 4'h5 |->
		reg_rdata_o == 32'h0) else $error("unmapped read not zero");
	mode_bit_a: assert property (reg_wr_i && reg_addr_i == 4'h0 |=>
		enhanced_o == $past(reg_wdata_i[7])) else $error("mode bit not followed");
	sw_sync_a: assert property (cfg_q[7] && sw_trig_i && !(|hw_trig_i) && !cnt_boundary_i |->
		sync_o == cfg_q[12:8]) else $error("software trigger loads wrong");
	load_quiet_a: assert property (!sw_trig_i && !(|hw_trig_i) && !cnt_boundary_i |->
		sync_o == 5'h0) else $error("load pulse without trigger");
	outctl_copy_a: assert property (!$past(cfg_q[5]) |-> outctl_o == $past(ob_q))
		else $error("output control not copied");
	swap_follow_a: assert property (!$past(cfg_q[4]) |-> ch_o == swp($past(ib_q), ch_i))
		else $error("pair swap wrong");
	init_copy_a: assert property (!$past(cfg_q[2]) |-> init_o == $past(init_buf_i))
		else $error("initial value not copied");
	cover property (sw_trig_i && sync_o.invert);
	cover property ((|hw_trig_i) && sync_o.counter);
	cover property (ch_o != ch_i);
endmodule // psi_sync_checker

bind psi_sync_ctrl psi_sync_checker #(.PAIRS(PAIRS), .HW_TRIGS(HW_TRIGS), .INIT_W(INIT_W)) chk_i (
	.mclk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
	.sw_trig_i, .hw_trig_i, .cnt_boundary_i, .init_buf_i, .ch_i, .ch_o, .outctl_o,
	.init_o, .sync_o, .enhanced_o);

// [psi_sync_ctrl.sv]
/*
 * PWM synchronization configuration and channel-pair inverting control.
 * Assumes: register port on mclk_i, software trigger and hardware trigger
 * detections are same-domain single-cycle pulses from the timer core; the
 * channel outputs come from the same core on the same clock.
 */
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "psi_consts.svh"
module psi_sync_ctrl #(
	parameter int PAIRS = 4,
	parameter int HW_TRIGS = 3,
	parameter int INIT_W = 16
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic sw_trig_i,
	input wire logic [HW_TRIGS-1:0] hw_trig_i,
	input wire logic cnt_boundary_i,
	input wire logic [INIT_W-1:0] init_buf_i,
	input wire logic [2*PAIRS-1:0] ch_i,
	output logic [2*PAIRS-1:0] ch_o,
	output logic [15:0] outctl_o,
	output logic [INIT_W-1:0] init_o,
	output psi_pkg::psi_sync_t sync_o,
	output logic enhanced_o
);
	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	psi_pkg::psi_bus_t bus;
	logic [31:0] cfg_q;
	logic [31:0] cfg_d;
	logic [HW_TRIGS-1:0] trig_en_q;
	logic [HW_TRIGS-1:0] trig_en_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic sw_pend_q;
	logic sw_pend_d;
	logic wr_cfg;
	logic wr_inv;
	logic wr_trig;
	logic wr_outctl;

	assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
	assign wr_cfg = bus.wr && (bus.addr == `PSI_REG_SYNC_CFG);
	assign wr_inv = bus.wr && (bus.addr == `PSI_REG_INV_CTRL);
	assign wr_trig = bus.wr && (bus.addr == `PSI_REG_TRIG_CTRL);
	assign wr_outctl = bus.wr && (bus.addr == `PSI_REG_OUTCTL);

	// Reserved positions are masked out on the way in, so they never store
	assign cfg_d = wr_cfg ? (bus.wdata & `PSI_SYNC_CFG_MASK) : cfg_q;

	// ----------------------------------------------------------------
	// Configuration fields
	// ----------------------------------------------------------------
	logic hold_mode;
	logic init_sel;
	logic inv_sel;
	logic outctl_sel;
	logic sync_mode;
	logic [4:0] sw_en;
	logic [4:0] hw_en;

	assign hold_mode = cfg_q[`PSI_B_HOLD_MODE];
	assign init_sel = cfg_q[`PSI_B_INIT_SEL];
	assign inv_sel = cfg_q[`PSI_B_INV_SEL];
	assign outctl_sel = cfg_q[`PSI_B_OUTCTL_SEL];
	assign sync_mode = cfg_q[`PSI_B_SYNC_MODE];
	assign sw_en = cfg_q[`PSI_B_SW_OUTCTL:`PSI_B_SW_COUNTER];
	assign hw_en = cfg_q[`PSI_B_HW_OUTCTL:`PSI_B_HW_COUNTER];

	// ----------------------------------------------------------------
	// Trigger detection
	// ----------------------------------------------------------------
	logic [HW_TRIGS-1:0] hw_hit;
	logic hw_any;
	logic sw_fire;

	// Only an enabled hardware trigger counts as detected
	assign hw_hit = hw_trig_i & trig_en_q;
	assign hw_any = |hw_hit;

	// Legacy waits for the counter boundary with the trigger held pending;
	// enhanced acts on the trigger itself.
	assign sw_fire = sync_mode ? sw_trig_i : (sw_pend_q || sw_trig_i) && cnt_boundary_i;
	assign sw_pend_d = sync_mode ? 1'b0 : (sw_pend_q || sw_trig_i) && !cnt_boundary_i;

	// Clear on detection in mode 0; a write in the same cycle loses to hardware
	assign trig_en_d = wr_trig ? (bus.wdata[HW_TRIGS-1:0] & ~(hold_mode ? '0 : hw_hit))
		: (hold_mode ? trig_en_q : trig_en_q & ~hw_hit);

	// ----------------------------------------------------------------
	// Per-target synchronization pulses
	// ----------------------------------------------------------------
	function automatic logic start_sync(input logic sw_bit, input logic hw_bit,
		input logic sw_ev, input logic hw_ev);
		start_sync = (sw_bit && sw_ev) || (hw_bit && hw_ev);
	endfunction

	psi_pkg::psi_sync_t sync;

	assign sync.outctl = start_sync(sw_en[4], hw_en[4], sw_fire, hw_any);
	assign sync.invert = start_sync(sw_en[3], hw_en[3], sw_fire, hw_any);
	assign sync.output_mask_register = start_sync(sw_en[2], hw_en[2], sw_fire, hw_any);
	assign sync.wrbuf = start_sync(sw_en[1], hw_en[1], sw_fire, hw_any);
	assign sync.counter = start_sync(sw_en[0], hw_en[0], sw_fire, hw_any);

	// ----------------------------------------------------------------
	// Buffered registers
	// ----------------------------------------------------------------
	logic [PAIRS-1:0] inv_buf;
	logic [PAIRS-1:0] inv_act;
	logic [15:0] outctl_buf;
	logic init_take;
	logic [INIT_W-1:0] init_q;

	// Bits 3..0 map straight to pairs 3..0
	psi_buf_reg #(.WIDTH(PAIRS)) u_inv (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.wr_i(wr_inv),
		.wdata_i(bus.wdata[PAIRS-1:0]),
		.sync_sel_i(inv_sel),
		.load_i(sync.invert),
		.buf_o(inv_buf),
		.act_o(inv_act)
	);

	psi_buf_reg #(.WIDTH(16)) u_outctl (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.wr_i(wr_outctl),
		.wdata_i(bus.wdata[15:0]),
		.sync_sel_i(outctl_sel),
		.load_i(sync.outctl),
		.buf_o(outctl_buf),
		.act_o(outctl_o)
	);

	// Initial value buffer lives in the counter core; only its load timing is here.
	// Loaded straight from that buffer: a second stage would add a cycle of lag.
	assign init_take = !init_sel || sync.wrbuf;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			init_q <= '0;
		end else if (init_take) begin
			init_q <= init_buf_i;
		end
	end

	assign init_o = init_q;

	psi_pair_swap #(.PAIRS(PAIRS)) u_swap (
		.inv_en_i(inv_act),
		.ch_i(ch_i),
		.ch_o(ch_o)
	);

	// ----------------------------------------------------------------
	// Read-back
	// ----------------------------------------------------------------
	logic [31:0] rd_inv;
	logic [31:0] rd_act;
	logic [31:0] rd_trig;
	logic [31:0] rd_status;

	// Unused upper bits read zero
	assign rd_inv = {{(32-PAIRS){1'b0}}, inv_buf};
	assign rd_act = {{(32-PAIRS){1'b0}}, inv_act};
	assign rd_trig = {{(32-HW_TRIGS){1'b0}}, trig_en_q};
	assign rd_status = {31'h0, sw_pend_q};

	always_comb begin
		rdata_d = 32'h0;
		if (bus.rd) begin
			unique case (bus.addr)
				`PSI_REG_SYNC_CFG: rdata_d = cfg_q;
				`PSI_REG_INV_CTRL: rdata_d = rd_inv;
				`PSI_REG_INV_ACTIVE: rdata_d = rd_act;
				`PSI_REG_TRIG_CTRL: rdata_d = rd_trig;
				`PSI_REG_OUTCTL: rdata_d = {16'h0, outctl_buf};
				`PSI_REG_STATUS: rdata_d = rd_status;
				default: rdata_d = 32'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cfg_q <= `PSI_SYNC_CFG_RST;
			trig_en_q <= '0;
			sw_pend_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			cfg_q <= cfg_d;
			trig_en_q <= trig_en_d;
			sw_pend_q <= sw_pend_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign sync_o = sync;
	assign enhanced_o = sync_mode;
endmodule // psi_sync_ctrl

// [tb_psi_sync_ctrl.sv]
/* Self-checking bench for psi_sync_ctrl: register port, triggers, loads.
 * Assumes the checker file is compiled before this one. */
`timescale 1ns/100ps
`include "psi_consts.svh"
module tb_psi_sync_ctrl;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [3:0] reg_addr_i = 4'h0;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic sw_trig_i = 1'b0;
	logic cnt_boundary_i = 1'b0;
	logic [2:0] hw_trig_i = 3'h0;
	logic [15:0] init_buf_i = 16'h0;
	logic [7:0] ch_i = 8'h99;
	logic [31:0] reg_rdata_o;
	logic [7:0] ch_o;
	logic [15:0] outctl_o;
	logic [15:0] init_o;
	psi_pkg::psi_sync_t sync_o;
	logic enhanced_o;
	int mismatches = 0;
	int cmp_count = 0;
	always #25 mclk_i = ~mclk_i;
	psi_sync_ctrl uut (.mclk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .sw_trig_i, .hw_trig_i, .cnt_boundary_i, .init_buf_i, .ch_i, .ch_o,
		.outctl_o, .init_o, .sync_o, .enhanced_o);
	// ----
	// Bus and compare helpers
	// ----
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		@(negedge mclk_i);
		chk("read data", e, reg_rdata_o);
	endtask
	// Pulse is judged in its own cycle because the load pulses are combinational
	task automatic pulse(input logic s, input logic [2:0] h, input logic b, input logic [4:0] e);
		@(posedge mclk_i);
		sw_trig_i <= s;
		hw_trig_i <= h;
		cnt_boundary_i <= b;
		@(negedge mclk_i);
		chk("sync pulses", {27'h0, e}, {27'h0, sync_o});
		@(posedge mclk_i);
		sw_trig_i <= 1'b0;
		hw_trig_i <= 3'h0;
		cnt_boundary_i <= 1'b0;
	endtask
	task automatic s_regs;
		rc(4'h0, 32'h0);
		rc(4'h1, 32'h0);
		wr(4'h0, 32'hFFFFFFFF);
		wr(4'h1, 32'hFFFFFFFF);
		rc(4'h0, `PSI_SYNC_CFG_MASK);
		chk("mode", 32'h1, {31'h0, enhanced_o});
		rc(4'h1, 32'hF);
		rc(4'h9, 32'h0);
		wr(4'h1, 32'h0);
		wr(4'h0, 32'h0);
	endtask
	task automatic s_sw;
		for (int k = 0; k < 5; k++) begin
			wr(4'h0, 32'h80 | (32'h100 << k));
			pulse(1'b1, 3'h0, 1'b0, 5'h1 << k);
		end
		wr(4'h0, 32'h80);
		pulse(1'b1, 3'h0, 1'b0, 5'h0);
	endtask
	task automatic s_inv;
		wr(4'h0, 32'h890);
		wr(4'h1, 32'h5);
		repeat (2) @(negedge mclk_i);
		chk("pair outputs", 32'h99, {24'h0, ch_o});
		rc(4'h2, 32'h0);
		pulse(1'b1, 3'h0, 1'b0, 5'h08);
		@(negedge mclk_i);
		chk("pair outputs", 32'hAA, {24'h0, ch_o});
		rc(4'h2, 32'h5);
		wr(4'h0, 32'h0);
		wr(4'h1, 32'h0);
		repeat (2) @(negedge mclk_i);
		chk("pair outputs", 32'h99, {24'h0, ch_o});
		wr(4'h1, 32'hA);
		repeat (2) @(negedge mclk_i);
		chk("pair outputs", 32'h55, {24'h0, ch_o});
		wr(4'h1, 32'h0);
	endtask
	task automatic s_out;
		wr(4'h0, 32'h10A0);
		wr(4'h4, 32'h1234);
		repeat (2) @(negedge mclk_i);
		chk("output control", 32'h0, {16'h0, outctl_o});
		pulse(1'b1, 3'h0, 1'b0, 5'h10);
		@(negedge mclk_i);
		chk("output control", 32'h1234, {16'h0, outctl_o});
		wr(4'h0, 32'h0);
		wr(4'h4, 32'hABCD);
		repeat (2) @(negedge mclk_i);
		chk("output control", 32'hABCD, {16'h0, outctl_o});
	endtask
	task automatic s_init;
		@(posedge mclk_i);
		init_buf_i <= 16'h55AA;
		repeat (2) @(negedge mclk_i);
		chk("initial value", 32'h55AA, {16'h0, init_o});
		wr(4'h0, 32'h284);
		@(posedge mclk_i);
		init_buf_i <= 16'h1111;
		repeat (2) @(negedge mclk_i);
		chk("initial value", 32'h55AA, {16'h0, init_o});
		pulse(1'b1, 3'h0, 1'b0, 5'h02);
		@(negedge mclk_i);
		chk("initial value", 32'h1111, {16'h0, init_o});
	endtask
	task automatic s_legacy;
		wr(4'h0, 32'h800);
		pulse(1'b1, 3'h0, 1'b0, 5'h0);
		rc(4'h5, 32'h1);
		pulse(1'b0, 3'h0, 1'b1, 5'h08);
	endtask
	task automatic s_hw;
		wr(4'h0, 32'h10080);
		wr(4'h3, 32'h7);
		pulse(1'b0, 3'h2, 1'b0, 5'h01);
		rc(4'h3, 32'h5);
		pulse(1'b0, 3'h2, 1'b0, 5'h0);
		wr(4'h0, 32'h10181);
		wr(4'h3, 32'h7);
		pulse(1'b0, 3'h1, 1'b0, 5'h01);
		rc(4'h3, 32'h7);
		pulse(1'b1, 3'h0, 1'b0, 5'h01);
	endtask
	task automatic results;
		$display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge mclk_i);
		srst_i <= 1'b0;
		s_regs();
		s_sw();
		s_inv();
		s_out();
		s_init();
		s_legacy();
		s_hw();
		results();
	end
endmodule // tb_psi_sync_ctrl
